// file: core/usc_pkg.sv
// Shared constants, types and carriers for the USB status and endpoint control block
package usc_pkg;

  // Clock and bit rates
  localparam int unsigned CLK_HZ        = 20_000_000;
  localparam int unsigned FS_BIT_HZ     = 12_000_000;
  localparam int unsigned LS_BIT_HZ     = 1_500_000;
  localparam int unsigned FS_DIV_CYC    = (CLK_HZ / FS_BIT_HZ) < 1 ? 1 : (CLK_HZ / FS_BIT_HZ);
  localparam int unsigned LS_DIV_CYC    = (CLK_HZ / LS_BIT_HZ) < 1 ? 1 : (CLK_HZ / LS_BIT_HZ);
  localparam int unsigned REASSERT_TCY  = 6;

  // Register byte offsets
  localparam logic [11:0] OFS_CFG       = 12'h000;
  localparam logic [11:0] OFS_CTRL      = 12'h004;
  localparam logic [11:0] OFS_XFER_FLAG = 12'h008;
  localparam logic [11:0] OFS_STATUS    = 12'h00C;
  localparam logic [11:0] OFS_ADDR      = 12'h010;
  localparam logic [11:0] OFS_FRML      = 12'h014;
  localparam logic [11:0] OFS_FRMH      = 12'h018;
  localparam logic [11:0] OFS_EP_BASE   = 12'h040;
  localparam logic [11:0] OFS_EP_LAST   = 12'h07C;

  // Configuration fields
  localparam int unsigned CFG_EYE   = 7;
  localparam int unsigned CFG_PUEN  = 4;
  localparam int unsigned CFG_TRDIS = 3;
  localparam int unsigned CFG_FULL_SPEED_SELECT  = 2;
  localparam logic [7:0]  CFG_MASK  = 8'h9F;
  localparam logic [7:0]  CFG_RST   = 8'h00;

  // Control fields
  localparam int unsigned CTL_EN   = 0;
  localparam int unsigned CTL_SUSP = 1;
  localparam logic [1:0]  CTL_RST  = 2'h0;

  // Endpoint control fields
  localparam int unsigned EP_HSHK   = 4;
  localparam int unsigned EP_SETDIS = 3;
  localparam int unsigned EP_OUTEN  = 2;
  localparam int unsigned EP_INEN   = 1;
  localparam int unsigned EP_STALL  = 0;
  localparam logic [4:0]  EP_RST    = 5'h00;

  // Status entry fields
  localparam int unsigned ST_ENDP_LSB = 3;
  localparam int unsigned ST_DIR      = 2;
  localparam int unsigned ST_ODD      = 1;

  localparam logic [6:0] ADDR_RST = 7'h00;

  // Dual-access memory map in core data space
  localparam logic [11:0] RAM_LO = 12'h060;
  localparam logic [11:0] RAM_HI = 12'hF3F;
  localparam logic [11:0] BDT_LO = 12'h400;
  localparam logic [11:0] BDT_HI = 12'h4FF;

  typedef enum logic [3:0] {
    PID_OUT   = 4'h1,
    PID_SOF   = 4'h5,
    PID_IN    = 4'h9,
    PID_SETUP = 4'hD
  } usc_pid_e;

  typedef enum logic [4:0] {
    RSP_NONE   = 5'b00001,
    RSP_ACCEPT = 5'b00010,
    RSP_NOHS   = 5'b00100,
    RSP_NAK    = 5'b01000,
    RSP_STALL  = 5'b10000
  } usc_rsp_e;

  typedef enum logic [1:0] {
    EYE_IDLE = 2'b01,
    EYE_RUN  = 2'b10
  } usc_eye_e;

  typedef struct packed {
    logic       valid;
    usc_pid_e   pid;
    logic [6:0] addr;
    logic [3:0] endp;
    logic [10:0] frame;
  } usc_tok_s;

  typedef struct packed {
    logic       valid;
    logic [3:0] endp;
    logic       dir_in;
    logic       odd;
  } usc_done_s;

  typedef struct packed {
    logic       valid;
    logic [3:0] endp;
  } usc_stall_s;

endpackage

// file: core/usc_sie_ctrl.sv
// Status FIFO, endpoint control, address, frame number, pull-up and eye test logic
//
// The register addresses and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps

module usc_sie_ctrl #(
  parameter int unsigned DEPTH = 4
) (
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [11:0]        paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire usc_pkg::usc_tok_s  tok,
  input  wire usc_pkg::usc_done_s done,
  input  wire usc_pkg::usc_stall_s stall_evt,
  input  wire logic               bus_reset_flag,
  output usc_pkg::usc_rsp_e       rsp,
  output logic                    transfer_done_flag,
  output logic                    fifo_full,
  output logic                    eye_tx_en,
  output logic                    eye_dp,
  output logic                    eye_dm,
  output logic                    pullup_dp,
  output logic                    pullup_dm,
  input  wire logic [11:0]        cpu_daddr,
  output logic                    usb_ram_sel,
  output logic                    bdt_sel
);

  localparam int unsigned PW = $clog2(DEPTH);

  initial begin
    if (DEPTH < 2 || (1 << PW) != DEPTH) begin
      $error("DEPTH must be a power of two of at least 2");
    end
  end

  // Register state
  logic [7:0]        cfg_q, cfg_d;
  logic [1:0]        ctl_q, ctl_d;
  logic [6:0]        addr_q, addr_d;
  logic [10:0]       frame_q, frame_d;
  logic [4:0]        ep_q [16];
  logic [4:0]        ep_d [16];
  logic [31:0]       prdata_q, prdata_d;
  // Status FIFO state
  logic [5:0]        mem_q [DEPTH];
  logic [5:0]        mem_d [DEPTH];
  logic [PW-1:0]     wp_q, wp_d, rp_q, rp_d;
  logic [PW:0]       cnt_q, cnt_d;
  logic              flag_q, flag_d;
  // Response and eye state
  usc_pkg::usc_rsp_e rsp_q, rsp_d;
  usc_pkg::usc_eye_e eye_q, eye_d;
  logic [3:0]        div_q, div_d;
  logic              ph_q, ph_d;
  logic              ram_q, ram_d, bdt_q, bdt_d;

  logic wr_acc, rd_set, mapped, push, pop, full, mod_on, bit_tick;
  logic addressed, dir_ok, stall_eff;
  logic [4:0] tep;

  // Address decode shared by read mux and write path
  function automatic logic is_mapped(input logic [11:0] a);
    if (a == usc_pkg::OFS_CFG || a == usc_pkg::OFS_CTRL || a == usc_pkg::OFS_XFER_FLAG) begin
      is_mapped = 1'b1;
    end else if (a == usc_pkg::OFS_ADDR || a == usc_pkg::OFS_FRML || a == usc_pkg::OFS_FRMH) begin
      is_mapped = 1'b1;
    end else if (a == usc_pkg::OFS_STATUS) begin
      is_mapped = 1'b1;
    end else if (a >= usc_pkg::OFS_EP_BASE && a <= usc_pkg::OFS_EP_LAST && a[1:0] == 2'h0) begin
      is_mapped = 1'b1;
    end else begin
      is_mapped = 1'b0;
    end
  endfunction

  function automatic logic in_range(input logic [11:0] a, input logic [11:0] lo,
                                    input logic [11:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction

  // Bus qualifiers and engine-side decisions
  always_comb begin
    mapped    = is_mapped(paddr);
    wr_acc    = psel && penable && pwrite && mapped;
    rd_set    = psel && !penable && !pwrite;
    full      = (cnt_q == (PW+1)'(DEPTH));
    mod_on    = ctl_q[usc_pkg::CTL_EN] && !ctl_q[usc_pkg::CTL_SUSP];
    push      = done.valid && !full;
    pop       = wr_acc && (paddr == usc_pkg::OFS_XFER_FLAG) && pwdata[0] && flag_q;
    addressed = tok.valid && mod_on && (tok.addr == addr_q);
    tep       = ep_q[tok.endp];
    dir_ok    = ((tok.pid == usc_pkg::PID_OUT) && tep[usc_pkg::EP_OUTEN])
             || ((tok.pid == usc_pkg::PID_IN) && tep[usc_pkg::EP_INEN])
             || ((tok.pid == usc_pkg::PID_SETUP) && tep[usc_pkg::EP_OUTEN]
                 && tep[usc_pkg::EP_INEN] && !tep[usc_pkg::EP_SETDIS]);
    stall_eff = tep[usc_pkg::EP_STALL] && (tep[usc_pkg::EP_OUTEN] || tep[usc_pkg::EP_INEN]);
  end

  // Configuration, control, address and frame registers
  always_comb begin
    cfg_d   = cfg_q;
    ctl_d   = ctl_q;
    addr_d  = addr_q;
    frame_d = frame_q;
    if (wr_acc && paddr == usc_pkg::OFS_CFG) begin
      cfg_d = pwdata[7:0] & usc_pkg::CFG_MASK;
    end else if (wr_acc && paddr == usc_pkg::OFS_CTRL) begin
      ctl_d = pwdata[1:0];
    end
    if (wr_acc && paddr == usc_pkg::OFS_ADDR) begin
      addr_d = pwdata[6:0];
    end
    if (bus_reset_flag) begin
      addr_d = usc_pkg::ADDR_RST;
    end
    if (tok.valid && tok.pid == usc_pkg::PID_SOF && mod_on) begin
      frame_d = tok.frame;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q   <= usc_pkg::CFG_RST;
      ctl_q   <= usc_pkg::CTL_RST;
      addr_q  <= usc_pkg::ADDR_RST;
      frame_q <= 11'h000;
    end else begin
      cfg_q   <= cfg_d;
      ctl_q   <= ctl_d;
      addr_q  <= addr_d;
      frame_q <= frame_d;
    end
  end

  // Endpoint controls; an issued stall wins over a firmware write
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      ep_d[i] = ep_q[i];
      if (wr_acc && paddr == usc_pkg::OFS_EP_BASE + 12'(i * 4)) begin
        ep_d[i] = pwdata[4:0];
      end
      if (stall_evt.valid && stall_evt.endp == 4'(i)) begin
        ep_d[i][usc_pkg::EP_STALL] = 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ep_q <= '{default: usc_pkg::EP_RST};
    end else begin
      ep_q <= ep_d;
    end
  end

  // Status FIFO and transfer-done flag
  always_comb begin
    mem_d = mem_q;
    wp_d  = wp_q;
    rp_d  = rp_q;
    cnt_d = cnt_q;
    if (push) begin
      mem_d[wp_q] = {done.endp, done.dir_in, done.odd};
      wp_d        = wp_q + 1'b1;
    end
    if (pop) begin
      rp_d = rp_q + 1'b1;
    end
    cnt_d = cnt_q + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop};
    flag_d = (cnt_d != '0);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_q  <= '{default: 6'h00};
      wp_q   <= '0;
      rp_q   <= '0;
      cnt_q  <= '0;
      flag_q <= 1'b0;
    end else begin
      mem_q  <= mem_d;
      wp_q   <= wp_d;
      rp_q   <= rp_d;
      cnt_q  <= cnt_d;
      flag_q <= flag_d;
    end
  end

  // Token answer, registered one cycle after the token
  always_comb begin
    rsp_d = usc_pkg::RSP_NONE;
    if (addressed && tok.pid != usc_pkg::PID_SOF && dir_ok) begin
      if (stall_eff) begin
        rsp_d = usc_pkg::RSP_STALL;
      end else if (full) begin
        rsp_d = usc_pkg::RSP_NAK;
      end else if (tep[usc_pkg::EP_HSHK]) begin
        rsp_d = usc_pkg::RSP_ACCEPT;
      end else begin
        rsp_d = usc_pkg::RSP_NOHS;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rsp_q <= usc_pkg::RSP_NONE;
    end else begin
      rsp_q <= rsp_d;
    end
  end

  // Eye pattern generator with bit-rate divider
  always_comb begin
    eye_d    = eye_q;
    div_d    = div_q;
    ph_d     = ph_q;
    bit_tick = 1'b0;
    case (eye_q)
      usc_pkg::EYE_IDLE: begin
        ph_d  = 1'b0;
        div_d = '0;
        if (cfg_q[usc_pkg::CFG_EYE] && ctl_q[usc_pkg::CTL_EN]) begin
          eye_d = usc_pkg::EYE_RUN;
        end
      end
      usc_pkg::EYE_RUN: begin
        bit_tick = (div_q == 4'(cfg_q[usc_pkg::CFG_FULL_SPEED_SELECT] ? usc_pkg::FS_DIV_CYC - 1
                                                         : usc_pkg::LS_DIV_CYC - 1));
        div_d    = bit_tick ? 4'h0 : div_q + 4'h1;
        ph_d     = bit_tick ? !ph_q : ph_q;
        if (!(cfg_q[usc_pkg::CFG_EYE] && ctl_q[usc_pkg::CTL_EN])) begin
          eye_d = usc_pkg::EYE_IDLE;
        end
      end
      default: begin
        eye_d = usc_pkg::EYE_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      eye_q <= usc_pkg::EYE_IDLE;
      div_q <= 4'h0;
      ph_q  <= 1'b0;
    end else begin
      eye_q <= eye_d;
      div_q <= div_d;
      ph_q  <= ph_d;
    end
  end

  // Read data captured in the setup phase; RAM window decode
  always_comb begin
    prdata_d = prdata_q;
    ram_d    = in_range(cpu_daddr, usc_pkg::RAM_LO, usc_pkg::RAM_HI);
    bdt_d    = in_range(cpu_daddr, usc_pkg::BDT_LO, usc_pkg::BDT_HI);
    if (rd_set) begin
      prdata_d = 32'h0000_0000;
      if (paddr == usc_pkg::OFS_CFG) begin
        prdata_d[7:0] = cfg_q;
      end else if (paddr == usc_pkg::OFS_CTRL) begin
        prdata_d[1:0] = ctl_q;
      end else if (paddr == usc_pkg::OFS_XFER_FLAG) begin
        prdata_d[0] = flag_q;
      end else if (paddr == usc_pkg::OFS_STATUS) begin
        prdata_d[6:1] = mem_q[rp_q];
      end else if (paddr == usc_pkg::OFS_ADDR) begin
        prdata_d[6:0] = addr_q;
      end else if (paddr == usc_pkg::OFS_FRML) begin
        prdata_d[7:0] = frame_q[7:0];
      end else if (paddr == usc_pkg::OFS_FRMH) begin
        prdata_d[2:0] = frame_q[10:8];
      end else if (is_mapped(paddr)) begin
        prdata_d[4:0] = ep_q[paddr[5:2]];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
      ram_q    <= 1'b0;
      bdt_q    <= 1'b0;
    end else begin
      prdata_q <= prdata_d;
      ram_q    <= ram_d;
      bdt_q    <= bdt_d;
    end
  end

  // Outputs
  assign prdata             = prdata_q;
  assign pready             = 1'b1;
  assign pslverr            = psel && penable && !mapped;
  assign rsp                = rsp_q;
  assign transfer_done_flag = flag_q;
  assign fifo_full          = full;
  assign eye_tx_en          = (eye_q == usc_pkg::EYE_RUN);
  assign eye_dp             = eye_tx_en && ph_q;
  assign eye_dm             = eye_tx_en && !ph_q;
  assign pullup_dp          = cfg_q[usc_pkg::CFG_PUEN] && !cfg_q[usc_pkg::CFG_TRDIS]
                              && cfg_q[usc_pkg::CFG_FULL_SPEED_SELECT];
  assign pullup_dm          = cfg_q[usc_pkg::CFG_PUEN] && !cfg_q[usc_pkg::CFG_TRDIS]
                              && !cfg_q[usc_pkg::CFG_FULL_SPEED_SELECT];
  assign usb_ram_sel        = ram_q;
  assign bdt_sel            = bdt_q;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_fifo_nak_full: assert property (addressed && tok.pid != usc_pkg::PID_SOF && dir_ok
    && !stall_eff && full |=> rsp == usc_pkg::RSP_NAK) else $error("full FIFO not NAKed");
  a_flag_reassert: assert property (pop && cnt_q > 1 |-> ##[1:6] flag_q)
    else $error("flag not reasserted");
  a_flag_drop: assert property ($fell(flag_q) |-> cnt_q == 0)
    else $error("flag fell with entries left");
  a_push_count: assert property (push && !pop |=> cnt_q == $past(cnt_q) + 1'b1)
    else $error("push not counted");
  a_addr_clear: assert property (bus_reset_flag |=> addr_q == 7'h00)
    else $error("address not cleared");
  a_frame_load: assert property (tok.valid && tok.pid == usc_pkg::PID_SOF && mod_on
    |=> frame_q == $past(tok.frame)) else $error("frame not loaded");
  a_pullup_gate: assert property ((pullup_dp || pullup_dm) |-> cfg_q[usc_pkg::CFG_PUEN]
    && !cfg_q[usc_pkg::CFG_TRDIS]) else $error("pull-up without enable");
  a_eye_toggle: assert property (eye_tx_en && bit_tick && eye_d == usc_pkg::EYE_RUN
    |=> eye_dp != $past(eye_dp) && eye_dm == !eye_dp) else $error("eye pattern stuck");
  a_stall_sticky: assert property (stall_evt.valid |=> ep_q[$past(stall_evt.endp)][0])
    else $error("stall flag not set");
  a_setup_refuse: assert property (addressed && tok.pid == usc_pkg::PID_SETUP
    && tep[usc_pkg::EP_SETDIS] |=> rsp == usc_pkg::RSP_NONE) else $error("SETUP accepted");
  a_in_refuse: assert property (addressed && tok.pid == usc_pkg::PID_IN
    && !tep[usc_pkg::EP_INEN] |=> rsp == usc_pkg::RSP_NONE) else $error("IN accepted");
  a_read_stable: assert property (rd_set && paddr == usc_pkg::OFS_STATUS && !done.valid
    |=> cnt_q == $past(cnt_q)) else $error("status read moved FIFO");
endmodule // usc_sie_ctrl

// file: verif/usc_host_model.sv
// Host side token source for the serial interface engine
`timescale 1ns/1ps
module usc_host_model (
  input  wire logic              pclk,
  input  wire usc_pkg::usc_rsp_e rsp,
  output usc_pkg::usc_tok_s      tok
);
  // Idle lines start quiet
  initial tok = '0;

  // One token per call; the answer is sampled in the cycle after the token
  task automatic send(input logic [3:0] pid, input logic [6:0] addr,
                      input logic [3:0] endp, input logic [10:0] frame,
                      output logic [4:0] ans);
    @(posedge pclk);
    tok <= {1'b1, pid, addr, endp, frame};
    @(posedge pclk);
    tok <= {1'b0, ~pid, ~addr, ~endp, ~frame}; // Released fields show no stale value
    #1;
    ans = rsp;
  endtask
endmodule // usc_host_model

// file: verif/usc_sie_ctrl_tb_top.sv
// Self-checking bench for the status and endpoint control block
`timescale 1ns/1ps
module usc_sie_ctrl_tb_top;
  logic                pclk, presetn, psel, penable, pwrite, bus_reset_flag;
  logic [11:0]         paddr, cpu_daddr;
  logic [31:0]         pwdata, prdata, q;
  logic                pready, pslverr, flag, full, eye_en, eye_dp, eye_dm;
  logic                pu_dp, pu_dm, ram_sel, bdt_sel, e, p;
  logic [4:0]          a;
  usc_pkg::usc_tok_s   tok;
  usc_pkg::usc_done_s  done;
  usc_pkg::usc_stall_s stall_evt;
  usc_pkg::usc_rsp_e   rsp;
  int                  err_count, check_count, bad, t, i, k;
  // Endpoint control, token code, expected answer
  localparam logic [13:0] ROWS [9] = '{14'h2D22, 14'h0C24, 14'h2421, 14'h2921, 14'h2DA2,
                                       14'h3DA1, 14'h2F30, 14'h0321, 14'h29A1};
  // Config value, expected D+ and D- pull-ups
  localparam logic [9:0]  PU [4]   = '{10'h052, 10'h041, 10'h010, 10'h070};
  // Data address, expected RAM and descriptor selects
  localparam logic [13:0] RAM [6]  = '{14'h0182, 14'h017C, 14'h1003, 14'h13FF, 14'h3CFE,
                                       14'h3D00};
  localparam logic [11:0] EP1      = usc_pkg::OFS_EP_BASE + 12'h004;

  usc_sie_ctrl uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tok(tok), .done(done), .stall_evt(stall_evt), .bus_reset_flag(bus_reset_flag),
    .rsp(rsp), .transfer_done_flag(flag), .fifo_full(full), .eye_tx_en(eye_en),
    .eye_dp(eye_dp), .eye_dm(eye_dm), .pullup_dp(pu_dp), .pullup_dm(pu_dm),
    .cpu_daddr(cpu_daddr), .usb_ram_sel(ram_sel), .bdt_sel(bdt_sel)
  );

  usc_host_model host (.pclk(pclk), .rsp(rsp), .tok(tok));

  // Clock
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic chk_rsp(input logic [4:0] got, input logic [4:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: answer %b want %b", $time, got, exp);
    end
  endtask

  // One APB transfer, held until pready is seen high
  task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      err_count++;
      $display("unexpected at %0t: no bus answer", $time);
      conclude();
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] ad, input logic [31:0] d);
    apb(1'b1, ad, d);
  endtask

  task automatic rdc(input logic [11:0] ad, input logic [31:0] exp);
    apb(1'b0, ad, 32'h0);
    chk(q, exp);
  endtask

  // Bounded wait for the completion flag to reach a level
  task automatic wait_flag(input logic x);
    int n;
    n = 0;
    #1;
    while (flag !== x && n < 6) begin
      @(posedge pclk);
      #1;
      n++;
    end
    chk(flag, x);
  endtask

  task automatic push(input logic [3:0] ep, input logic dir, input logic odd);
    @(posedge pclk);
    done <= {1'b1, ep, dir, odd};
    @(posedge pclk);
    done <= '0;
  endtask

  // Eye pattern: lines opposite and toggling while enabled
  task automatic eye_run(input logic [7:0] c);
    wr(usc_pkg::OFS_CFG, {24'h0, c});
    @(posedge pclk);
    #1;
    chk({eye_en, eye_dp, eye_dm}, 3'b101);
    bad = 0;
    t = 0;
    p = eye_dp;
    repeat (30) begin
      @(posedge pclk);
      #1;
      if (eye_dp === eye_dm) bad++;
      if (eye_dp !== p) t++;
      p = eye_dp;
    end
    chk(bad, 0);
    chk(t >= 2, 1);
    wr(usc_pkg::OFS_CFG, 32'h0);
    @(posedge pclk);
    #1;
    chk(eye_en, 0);
  endtask

  // Main sequence
  initial begin
    {presetn, psel, penable, pwrite, bus_reset_flag} = '0;
    {paddr, cpu_daddr, pwdata} = '0;
    {done, stall_evt} = '0;
    {err_count, check_count} = '0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    for (i = 0; i < 16; i++) rdc(usc_pkg::OFS_EP_BASE + 12'(4 * i), 32'h0);
    rdc(usc_pkg::OFS_ADDR, 32'h0);
    rdc(12'h020, 32'h0);
    chk(e, 1);
    wr(usc_pkg::OFS_CTRL, 32'h1);
    foreach (ROWS[i]) begin
      wr(EP1, {27'h0, ROWS[i][13:9]});
      host.send(ROWS[i][8:5], 7'h00, 4'h1, 11'h000, a);
      chk_rsp(a, ROWS[i][4:0]);
      rdc(EP1, {27'h0, ROWS[i][13:9]});
    end
    wr(usc_pkg::OFS_EP_BASE, 32'h16);
    host.send(usc_pkg::PID_SETUP, 7'h00, 4'h0, 11'h000, a);
    chk_rsp(a, usc_pkg::RSP_ACCEPT);
    wr(EP1, 32'h16);
    wr(usc_pkg::OFS_ADDR, 32'h5);
    host.send(usc_pkg::PID_IN, 7'h00, 4'h1, 11'h000, a);
    chk_rsp(a, usc_pkg::RSP_NONE);
    host.send(usc_pkg::PID_IN, 7'h05, 4'h1, 11'h000, a);
    chk_rsp(a, usc_pkg::RSP_ACCEPT);
    @(posedge pclk);
    bus_reset_flag <= 1'b1;
    @(posedge pclk);
    bus_reset_flag <= 1'b0;
    rdc(usc_pkg::OFS_ADDR, 32'h0);
    @(posedge pclk);
    stall_evt <= {1'b1, 4'h1};
    @(posedge pclk);
    stall_evt <= '0;
    rdc(EP1, 32'h17);
    host.send(usc_pkg::PID_OUT, 7'h00, 4'h1, 11'h000, a);
    chk_rsp(a, usc_pkg::RSP_STALL);
    wr(EP1, 32'h16);
    for (k = 0; k < 5; k++) push(4'(k * 5), k[0], k[1]);
    #1;
    chk({flag, full}, 2'b11);
    host.send(usc_pkg::PID_IN, 7'h00, 4'h1, 11'h000, a);
    chk_rsp(a, usc_pkg::RSP_NAK);
    for (k = 0; k < 4; k++) begin
      rdc(usc_pkg::OFS_STATUS, {25'h0, 4'(k * 5), k[0], k[1], 1'b0});
      rdc(usc_pkg::OFS_STATUS, {25'h0, 4'(k * 5), k[0], k[1], 1'b0});
      wr(usc_pkg::OFS_XFER_FLAG, 32'h1);
      wait_flag(k < 3);
    end
    host.send(usc_pkg::PID_SOF, 7'h00, 4'h0, 11'h5A3, a);
    rdc(usc_pkg::OFS_FRML, 32'hA3);
    rdc(usc_pkg::OFS_FRMH, 32'h5);
    wr(usc_pkg::OFS_CTRL, 32'h3);
    host.send(usc_pkg::PID_SOF, 7'h00, 4'h0, 11'h2FF, a);
    rdc(usc_pkg::OFS_FRML, 32'hA3);
    wr(usc_pkg::OFS_CTRL, 32'h1);
    eye_run(8'h80);
    eye_run(8'h84);
    wr(usc_pkg::OFS_CFG, 32'h0);
    #1;
    chk(eye_en, 0);
    wr(usc_pkg::OFS_CTRL, 32'h0);
    wr(usc_pkg::OFS_CFG, 32'h80);
    repeat (3) @(posedge pclk);
    #1;
    chk(eye_en, 0);
    wr(usc_pkg::OFS_CFG, 32'hFF);
    rdc(usc_pkg::OFS_CFG, 32'h9F);
    foreach (PU[i]) begin
      wr(usc_pkg::OFS_CFG, {24'h0, PU[i][9:2]});
      #1;
      chk({pu_dp, pu_dm}, PU[i][1:0]);
    end
    foreach (RAM[i]) begin
      @(posedge pclk);
      cpu_daddr <= RAM[i][13:2];
      repeat (2) @(posedge pclk);
      #1;
      chk({ram_sel, bdt_sel}, RAM[i][1:0]);
    end
    // Reset in mid-run clears address, endpoints and FIFO
    wr(usc_pkg::OFS_ADDR, 32'h5);
    push(4'h3, 1'b1, 1'b0);
    #1;
    chk(flag, 1);
    @(posedge pclk);
    presetn <= 1'b0;
    @(posedge pclk);
    #1;
    chk({flag, full, eye_en, pu_dp, pu_dm}, 5'h00);
    @(posedge pclk);
    presetn <= 1'b1;
    rdc(usc_pkg::OFS_ADDR, 32'h0);
    rdc(EP1, 32'h0);
    conclude();
  end

  // Watchdog for the whole run
  initial begin
    repeat (100000) @(posedge pclk);
    err_count++;
    $display("unexpected at %0t: run too long", $time);
    conclude();
  end
endmodule // usc_sie_ctrl_tb_top
